// ### inc/rsf_pkg.sv
// constants shared by the reset source filter and flag logic
package rsf_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int PIN_FILTER_US     = 36;
  localparam int PIN_FILTER_CYC    = (PIN_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LV_SETTLE_US      = 100;
  localparam int LV_SETTLE_CYC     = (LV_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LV_DEGLITCH_CYC   = 16;
  localparam int CNT_W             = 16;
  // =====================================================================
  // reset-source register layout
  localparam int SRC_W             = 8;
  localparam int SRC_POR_BIT       = 0;
  localparam int SRC_PIN_BIT       = 1;
  localparam int SRC_WDOG_BIT      = 2;
  localparam int SRC_LV_BIT        = 3;
  localparam int SRC_BOD_BIT       = 4;
  localparam int SRC_SYSREQ_BIT    = 5;
  localparam int SRC_CPU_BIT       = 7;
  localparam logic [7:0] SRC_RESET = 8'h00;
  // brownout control register: low-voltage reset enable position
  localparam int BOD_LVEN_BIT      = 7;
  // clock status layout: stable flags bits 4:0, switch fail bit 7
  localparam int CLKST_W           = 8;
  localparam int CLKST_FAIL_BIT    = 7;
  localparam logic [7:0] CLKST_STB_MASK = 8'h1f;
  // configuration fields
  localparam int CFG0_WDOG_BIT     = 31;
  localparam int CFG0_BOOT_BIT     = 7;
  localparam int DFBASE_W          = 20;
  localparam logic [19:0] DFBASE_RESET = 20'h00000;
  // low-voltage state machine
  typedef enum logic [1:0] {
    RSF_LV_OFF    = 2'b00,
    RSF_LV_SETTLE = 2'b01,
    RSF_LV_ACTIVE = 2'b10
  } rsf_lv_type;
endpackage

// ### logic/rsf_filter.sv
// per-input persistence filter: output follows input after it holds N cycles
`timescale 1ns/1ns
module rsf_filter #(
  parameter int                  HOLD = 16,
  parameter logic                INIT = 1'b0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // data
  input  wire logic              din,
  output logic                   dout
);
  import rsf_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  // =====================================================================
  // counter runs while input differs from output; output flips at HOLD
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      dout  <= INIT;
    end else if (ce) begin
      if (din == dout) begin
        cnt_r <= '0;
      end else if (cnt_r == CNT_W'(HOLD - 1)) begin
        cnt_r <= '0;
        dout  <= din;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ### logic/rsf_reset_source_filter_and_flags.sv
// reset generation, source recording and per-source reload logic
//
// How it works
// RULE1 - the reset pin is sampled at any time and asserts reset only after staying low 36 us.
// RULE2 - after a pin reset, reset is held until the pin has stayed high 36 us.
// RULE3 - a pin reset sets the pin-reset flag at bit 1 of the reset-source register.
// RULE4 - while supply rises, reset is held until the power-on detector reports ready.
// RULE5 - a power-on reset sets the power-on flag at bit 0.
// RULE6 - writing 1 clears the power-on flag and writing 0 leaves it.
// RULE7 - setting the low-voltage enable starts a 100 us settle before the function is active.
// RULE8 - when active, reset is asserted only after low supply persists 16 clock cycles.
// RULE9 - after a low-voltage reset, release waits until supply-ok persists 16 cycles.
// RULE10 - each source sets its own reset-source bit; a chip software reset sets bit 0.
// RULE11 - oscillator and PLL stable flags clear only on power-on; switch-fail clears on all but CPU.
// RULE12 - all but system-request and CPU resets reload watchdog, boot select and flash base.
`timescale 1ns/1ns
module rsf_reset_source_filter_and_flags (
  // clock, reset, enable (rst is the power-on detector's not-ready level)
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // reset sources
  input  wire logic                          externalResetPinN,
  input  wire logic                          lowVoltageDetect,
  input  wire logic                          watchdogReset,
  input  wire logic                          brownoutReset,
  input  wire logic                          chipSoftReset,
  input  wire logic                          sysRequestReset,
  input  wire logic                          cpuOnlyReset,
  // controls
  input  wire logic                          lowVoltageResetEnable,
  input  wire logic [rsf_pkg::SRC_W-1:0]     sourceClearMask,
  input  wire logic                          sourceClearStrobe,
  // clock stable inputs
  input  wire logic [rsf_pkg::CLKST_W-1:0]   clockStableSet,
  input  wire logic                          clockSwitchFail,
  // configuration words
  input  wire logic [31:0]                   configurationWordZero,
  input  wire logic [31:0]                   configurationWordOne,
  // outputs
  output logic                               chipReset,
  output logic                               cpuReset,
  output logic                               lowVoltageResetActive,
  output logic [rsf_pkg::SRC_W-1:0]          resetSourceRegister,
  output logic [rsf_pkg::CLKST_W-1:0]        clockStatusRegister,
  output logic                               watchdogEnableBit,
  output logic                               bootSelectBit,
  output logic [rsf_pkg::DFBASE_W-1:0]       dataFlashBaseAddress
);
  import rsf_pkg::*;

  // =====================================================================
  // pin synchroniser: three flops, change counts when stages 2 and 3 agree
  logic pinS1_r, pinS2_r, pinS3_r, pinAgreed_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1_r     <= 1'b1;
      pinS2_r     <= 1'b1;
      pinS3_r     <= 1'b1;
      pinAgreed_r <= 1'b1;
    end else if (ce) begin
      pinS1_r <= externalResetPinN;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      if (pinS2_r == pinS3_r) pinAgreed_r <= pinS3_r;
    end
  end

  // detector level through the same synchroniser style
  logic lvS1_r, lvS2_r, lvS3_r, lvAgreed_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      lvS1_r     <= 1'b0;
      lvS2_r     <= 1'b0;
      lvS3_r     <= 1'b0;
      lvAgreed_r <= 1'b0;
    end else if (ce) begin
      lvS1_r <= lowVoltageDetect;
      lvS2_r <= lvS1_r;
      lvS3_r <= lvS2_r;
      if (lvS2_r == lvS3_r) lvAgreed_r <= lvS3_r;
    end
  end

  // =====================================================================
  // pin glitch filter, both edges
  logic pinLowFilt;
  rsf_filter #(.HOLD(PIN_FILTER_CYC), .INIT(1'b0)) uPinFilter (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (~pinAgreed_r),
    .dout (pinLowFilt)
  ); // RULE1 RULE2

  // =====================================================================
  // low-voltage enable settle sequencer
  rsf_lv_type       lvState_r;
  logic [CNT_W-1:0] settleCnt_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      lvState_r   <= RSF_LV_OFF;
      settleCnt_r <= '0;
    end else if (ce) begin
      case (lvState_r)
        RSF_LV_OFF: begin
          settleCnt_r <= '0;
          if (lowVoltageResetEnable) lvState_r <= RSF_LV_SETTLE;
        end
        RSF_LV_SETTLE: begin
          if (!lowVoltageResetEnable) begin
            lvState_r <= RSF_LV_OFF;
          end else if (settleCnt_r == CNT_W'(LV_SETTLE_CYC - 1)) begin
            lvState_r <= RSF_LV_ACTIVE; // RULE7
          end else begin
            settleCnt_r <= settleCnt_r + 1'b1;
          end
        end
        RSF_LV_ACTIVE: begin
          if (!lowVoltageResetEnable) lvState_r <= RSF_LV_OFF;
        end
        default: lvState_r <= RSF_LV_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) lowVoltageResetActive <= 1'b0;
    else if (ce) lowVoltageResetActive <= (lvState_r == RSF_LV_ACTIVE);
  end

  // low-supply deglitch; gated by active state on entry only
  logic lvLowFilt;
  rsf_filter #(.HOLD(LV_DEGLITCH_CYC), .INIT(1'b0)) uLvFilter (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (lvAgreed_r),
    .dout (lvLowFilt)
  ); // RULE8 RULE9

  logic lvHold_r;
  always_ff @(posedge clk) begin
    if (rst) lvHold_r <= 1'b0;
    else if (ce) begin
      if (lvLowFilt && lowVoltageResetActive) lvHold_r <= 1'b1; // RULE8
      else if (!lvLowFilt) lvHold_r <= 1'b0; // RULE9
    end
  end

  // =====================================================================
  // chip reset request and rising edges of each source
  logic chipReq, pinPrev_r, lvPrev_r, wdPrev_r, bodPrev_r, chipPrev_r, sysPrev_r, cpuPrev_r;
  assign chipReq = pinLowFilt | lvHold_r | watchdogReset | brownoutReset |
                   chipSoftReset | sysRequestReset;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev_r  <= 1'b0;
      lvPrev_r   <= 1'b0;
      wdPrev_r   <= 1'b0;
      bodPrev_r  <= 1'b0;
      chipPrev_r <= 1'b0;
      sysPrev_r  <= 1'b0;
      cpuPrev_r  <= 1'b0;
    end else if (ce) begin
      pinPrev_r  <= pinLowFilt;
      lvPrev_r   <= lvHold_r;
      wdPrev_r   <= watchdogReset;
      bodPrev_r  <= brownoutReset;
      chipPrev_r <= chipSoftReset;
      sysPrev_r  <= sysRequestReset;
      cpuPrev_r  <= cpuOnlyReset;
    end
  end

  logic evPin, evLv, evWd, evBod, evChip, evSys, evCpu;
  assign evPin  = pinLowFilt & ~pinPrev_r;
  assign evLv   = lvHold_r & ~lvPrev_r;
  assign evWd   = watchdogReset & ~wdPrev_r;
  assign evBod  = brownoutReset & ~bodPrev_r;
  assign evChip = chipSoftReset & ~chipPrev_r;
  assign evSys  = sysRequestReset & ~sysPrev_r;
  assign evCpu  = cpuOnlyReset & ~cpuPrev_r;

  // chip reset held by power-on, then by any chip request (only pin and low-voltage are filtered)
  always_ff @(posedge clk) begin
    if (rst) begin
      chipReset <= 1'b1; // RULE4
      cpuReset  <= 1'b1;
    end else if (ce) begin
      chipReset <= chipReq; // RULE1 RULE2 RULE9
      cpuReset  <= chipReq | cpuOnlyReset;
    end
  end

  // =====================================================================
  // reset-source register; hardware set wins over software clear
  logic [SRC_W-1:0] srcSet, srcNxt;
  always_comb begin
    srcSet                 = '0;
    srcSet[SRC_POR_BIT]    = evChip; // RULE10
    srcSet[SRC_PIN_BIT]    = evPin; // RULE3
    srcSet[SRC_WDOG_BIT]   = evWd;
    srcSet[SRC_LV_BIT]     = evLv;
    srcSet[SRC_BOD_BIT]    = evBod;
    srcSet[SRC_SYSREQ_BIT] = evSys;
    srcSet[SRC_CPU_BIT]    = evCpu;
    srcNxt = resetSourceRegister & ~(sourceClearStrobe ? sourceClearMask : '0); // RULE6
    srcNxt = srcNxt | srcSet;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resetSourceRegister              <= SRC_RESET;
      resetSourceRegister[SRC_POR_BIT] <= 1'b1; // RULE5
    end else if (ce) begin
      resetSourceRegister <= srcNxt;
    end
  end

  // =====================================================================
  // clock status: stable bits cleared only at power-on, fail cleared on non-cpu resets
  logic nonCpuEv;
  assign nonCpuEv = evPin | evLv | evWd | evBod | evChip | evSys;
  always_ff @(posedge clk) begin
    if (rst) begin
      clockStatusRegister <= '0; // RULE11
    end else if (ce) begin
      clockStatusRegister <= (clockStatusRegister | (clockStableSet & CLKST_STB_MASK));
      if (nonCpuEv) clockStatusRegister[CLKST_FAIL_BIT] <= 1'b0; // RULE11
      else if (clockSwitchFail) clockStatusRegister[CLKST_FAIL_BIT] <= 1'b1;
    end
  end

  // =====================================================================
  // configuration reload: power-on, pin, watchdog, low-voltage, brownout, chip
  logic reloadEv, reloadPend_r;
  assign reloadEv = evPin | evLv | evWd | evBod | evChip;
  always_ff @(posedge clk) begin
    if (rst) reloadPend_r <= 1'b1;
    else if (ce) reloadPend_r <= reloadEv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      watchdogEnableBit    <= 1'b0;
      bootSelectBit        <= 1'b0;
      dataFlashBaseAddress <= DFBASE_RESET;
    end else if (ce && reloadPend_r) begin
      watchdogEnableBit    <= configurationWordZero[CFG0_WDOG_BIT]; // RULE12
      bootSelectBit        <= configurationWordZero[CFG0_BOOT_BIT];
      dataFlashBaseAddress <= configurationWordOne[DFBASE_W-1:0];
    end
  end

  // =====================================================================
  // checks
  // helper for checks: run of consecutive low cycles of the agreed pin level
  logic [CNT_W-1:0] pinLowRun_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinLowRun_r <= '0;
    end else if (ce) begin
      if (pinAgreed_r) pinLowRun_r <= '0;
      else if (pinLowRun_r != '1) pinLowRun_r <= pinLowRun_r + 1'b1; // saturates
    end
  end

  a_por_flag_set: assert property (@(posedge clk) $fell(rst) |-> resetSourceRegister[0]) // RULE5
    else $error("power-on flag not set after power-on");
  a_pin_flag_set: assert property (@(posedge clk) disable iff (rst) // RULE3
    (ce && evPin) |=> resetSourceRegister[1])
    else $error("pin flag not set");
  a_por_clear: assert property (@(posedge clk) disable iff (rst) // RULE6
    (ce && sourceClearStrobe && sourceClearMask[0] && !evChip) |=> !resetSourceRegister[0])
    else $error("power-on flag not cleared");
  a_por_keep: assert property (@(posedge clk) disable iff (rst) // RULE6
    (ce && resetSourceRegister[0] && !(sourceClearStrobe && sourceClearMask[0]))
      |=> resetSourceRegister[0])
    else $error("power-on flag lost");
  a_reset_during_por: assert property (@(posedge clk) rst |=> chipReset) // RULE4
    else $error("reset not held during power-on");
  a_lv_settle: assert property (@(posedge clk) disable iff (rst) // RULE7
    $rose(lowVoltageResetActive) |-> $past(settleCnt_r) == CNT_W'(LV_SETTLE_CYC - 1))
    else $error("low-voltage active without settle");
  a_lv_ignore_off: assert property (@(posedge clk) disable iff (rst) // RULE8
    (ce && !lvHold_r && !lowVoltageResetActive) |=> !lvHold_r)
    else $error("low-voltage reset while inactive");
  a_pin_glitch: assert property (@(posedge clk) disable iff (rst) // RULE1
    (ce && $rose(pinLowFilt)) |-> $past(pinLowRun_r) >= CNT_W'(PIN_FILTER_CYC - 1))
    else $error("pin reset without a full filter time low");
  a_chip_follow: assert property (@(posedge clk) disable iff (rst) // RULE2
    (ce && pinLowFilt) |=> chipReset)
    else $error("chip reset not held for pin");
endmodule

// ### verif/rsf_detector_model.sv
// behavioural model of the power-on detector, reset pin and low-voltage detector
`timescale 1ns/1ns
module rsf_detector_model (
  // clock
  input  wire logic clk,
  // detector outputs
  output logic      rst,
  output logic      externalResetPinN,
  output logic      lowVoltageDetect
);
  // =====================================================================
  // idle levels: supply not ready, pin released high, supply ok
  initial begin
    rst               = 1'b1;
    externalResetPinN = 1'b1;
    lowVoltageDetect  = 1'b0;
  end

  // supply ramp: not-ready level held three cycles, then ready
  task automatic powerUp();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask

  // pin and supply levels change only at the falling edge
  task automatic drive(input logic pinLevel, input logic lowSupply);
    @(negedge clk);
    externalResetPinN = pinLevel;
    lowVoltageDetect  = lowSupply;
  endtask
endmodule

// ### verif/test_reset_source_filter_and_flags.sv
// self-checking testbench for the reset source filter and flag logic
`timescale 1ns/1ns
module test_reset_source_filter_and_flags;
  import rsf_pkg::*;
  // =====================================================================
  // stimulus and observed signals
  logic                clk;
  logic                ce;
  logic                lvEn;
  logic                clrStrobe;
  logic                swFail;
  logic [4:0]          req;
  logic [SRC_W-1:0]    clrMask;
  logic [CLKST_W-1:0]  stbSet;
  logic [31:0]         cfg0;
  logic [31:0]         cfg1;
  wire                 rst;
  wire                 pinN;
  wire                 lvDet;
  logic                chipReset;
  logic                cpuReset;
  logic                lvActive;
  logic [SRC_W-1:0]    rsr;
  logic [CLKST_W-1:0]  clkSt;
  logic                wdEn;
  logic                bootSel;
  logic [DFBASE_W-1:0] dfBase;
  logic                eWd;
  logic                eBoot;
  logic [DFBASE_W-1:0] eBase;
  int                  badCount;
  int                  comparisons;
  int                  srcBit [5] = '{SRC_WDOG_BIT, SRC_BOD_BIT, SRC_POR_BIT, SRC_SYSREQ_BIT,
                                      SRC_CPU_BIT};

  rsf_detector_model model (.clk(clk), .rst(rst), .externalResetPinN(pinN),
                            .lowVoltageDetect(lvDet));

  rsf_reset_source_filter_and_flags uut (
    .clk(clk), .rst(rst), .ce(ce), .externalResetPinN(pinN), .lowVoltageDetect(lvDet),
    .watchdogReset(req[0]), .brownoutReset(req[1]), .chipSoftReset(req[2]),
    .sysRequestReset(req[3]), .cpuOnlyReset(req[4]), .lowVoltageResetEnable(lvEn),
    .sourceClearMask(clrMask), .sourceClearStrobe(clrStrobe), .clockStableSet(stbSet),
    .clockSwitchFail(swFail), .configurationWordZero(cfg0), .configurationWordOne(cfg1),
    .chipReset(chipReset), .cpuReset(cpuReset), .lowVoltageResetActive(lvActive),
    .resetSourceRegister(rsr), .clockStatusRegister(clkSt), .watchdogEnableBit(wdEn),
    .bootSelectBit(bootSel), .dataFlashBaseAddress(dfBase));

  // =====================================================================
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare one value and count it
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write-1-to-clear strobe, result visible after next edge
  task automatic clearFlags(input logic [SRC_W-1:0] m);
    @(negedge clk);
    clrMask   = m;
    clrStrobe = 1'b1;
    @(negedge clk);
    clrStrobe = 1'b0;
    @(negedge clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, well beyond the expected 25000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    results();
  end

  // main sequence
  initial begin
    badCount = 0;
    comparisons = 0;
    ce = 1'b1;
    lvEn = 1'b0;
    clrStrobe = 1'b0;
    swFail = 1'b0;
    req = 5'h00;
    clrMask = 8'h00;
    stbSet = 8'h00;
    cfg0 = 32'h00000080;
    cfg1 = 32'h00012345;
    model.powerUp();
    check("reset held", 1'b1, chipReset);
    check("por flag", 8'h01, rsr);
    check("clock status", 8'h00, clkSt);
    tick(2);
    check("released", 1'b0, chipReset);
    check("boot select", 1'b1, bootSel);
    check("flash base", 20'h12345, dfBase);
    clearFlags(8'hfe);
    check("write 0 keeps", 8'h01, rsr);
    clearFlags(8'h01);
    check("write 1 clears", 8'h00, rsr);
    // clock enable low freezes flags and reset while a request stands
    ce = 1'b0;
    req[0] = 1'b1;
    tick(3);
    check("frozen flags", 8'h00, rsr);
    check("frozen reset", 1'b0, chipReset);
    req = 5'h00;
    tick(1);
    ce = 1'b1;
    // pin held low past the filter, then released past the filter
    model.drive(1'b0, 1'b0);
    tick(3590);
    check("pin early", 1'b0, chipReset);
    tick(30);
    check("pin reset", 1'b1, chipReset);
    check("pin flag", 8'h02, rsr);
    model.drive(1'b1, 1'b0);
    tick(3590);
    check("pin hold", 1'b1, chipReset);
    tick(30);
    check("pin release", 1'b0, chipReset);
    // glitch shorter than the filter is ignored
    clearFlags(8'hff);
    model.drive(1'b0, 1'b0);
    tick(3500);
    model.drive(1'b1, 1'b0);
    tick(3700);
    check("pin glitch", 1'b0, chipReset);
    check("glitch flags", 8'h00, rsr);
    // low-voltage settle, deglitch on entry and on release
    lvEn = 1'b1;
    tick(9990);
    check("lv settling", 1'b0, lvActive);
    tick(30);
    check("lv active", 1'b1, lvActive);
    model.drive(1'b1, 1'b1);
    tick(10);
    model.drive(1'b1, 1'b0);
    tick(40);
    check("lv short dip", 1'b0, chipReset);
    model.drive(1'b1, 1'b1);
    tick(40);
    check("lv reset", 1'b1, chipReset);
    check("lv flag", 8'h08, rsr);
    model.drive(1'b1, 1'b0);
    tick(10);
    check("lv hold", 1'b1, chipReset);
    tick(30);
    check("lv release", 1'b0, chipReset);
    lvEn = 1'b0;
    // remaining sources: flag bit, switch-fail clear and reload per source
    eWd = 1'b0;
    eBoot = 1'b1;
    eBase = 20'h12345;
    stbSet = 8'h1f;
    tick(2);
    stbSet = 8'h00;
    for (int i = 0; i < 5; i++) begin
      clearFlags(8'hff);
      swFail = 1'b1;
      tick(2);
      swFail = 1'b0;
      cfg0 = cfg0 ^ 32'h80000080;
      cfg1 = cfg1 ^ 32'h000abcde;
      if (i < 3) begin
        eWd = cfg0[CFG0_WDOG_BIT];
        eBoot = cfg0[CFG0_BOOT_BIT];
        eBase = cfg1[DFBASE_W-1:0];
      end
      req[i] = 1'b1;
      tick(2);
      check("chip reset", (i == 4) ? 1'b0 : 1'b1, chipReset);
      check("cpu reset", 1'b1, cpuReset);
      req = 5'h00;
      tick(40);
      check("cpu released", 1'b0, cpuReset);
      check("source flag", 8'h01 << srcBit[i], rsr);
      check("clock status", (i == 4) ? 8'h9f : 8'h1f, clkSt);
      check("watchdog enable", eWd, wdEn);
      check("boot select", eBoot, bootSel);
      check("flash base", eBase, dfBase);
    end
    // second power-on in mid-run: stable flags cleared, words reloaded
    cfg0 = 32'h00000080;
    cfg1 = 32'h00012345;
    model.powerUp();
    check("por again", 8'h01, rsr);
    check("stable cleared", 8'h00, clkSt);
    check("reset again", 1'b1, chipReset);
    tick(2);
    check("released again", 1'b0, chipReset);
    check("boot reload", 1'b1, bootSel);
    check("wdog reload", 1'b0, wdEn);
    check("base reload", 20'h12345, dfBase);
    results();
  end
endmodule
